// >>> shared/flbs_pkg.sv
// Purpose: shared constants and types for the flash lock, blank-check and status sequencer
// Assumes: 125 MHz clock, byte-wide command port, 1 KiB blocks in a 64 KiB space
// Notes: command codes and status bit positions live here only
package flbs_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int BLK_SHIFT = 10;
  localparam int BLK_W = ADDR_W - BLK_SHIFT;
  localparam int NUM_BLOCKS = 1 << BLK_W;

  // command codes
  localparam logic [DATA_W-1:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [DATA_W-1:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 8'h40;
  localparam logic [DATA_W-1:0] CMD_BLOCK_ERASE = 8'h20;
  localparam logic [DATA_W-1:0] CMD_LOCK_PROGRAM = 8'h77;
  localparam logic [DATA_W-1:0] CMD_LOCK_READ = 8'h71;
  localparam logic [DATA_W-1:0] CMD_BLANK_CHECK = 8'h25;
  localparam logic [DATA_W-1:0] CMD_CONFIRM = 8'hd0;
  localparam logic [DATA_W-1:0] BLANK_BYTE = 8'hff;

  // status register bit positions
  localparam int ST_READY_BIT = 7;
  localparam int ST_SUSPEND_BIT = 6;
  localparam int ST_EB_ERR_BIT = 5;
  localparam int ST_PROG_ERR_BIT = 4;
  localparam int ST_LOCK_BIT = 0;

  // reset values
  localparam logic LOCK_RESET_VAL = 1'b1;
  localparam logic LOCK_DATA_RESET_VAL = 1'b0;
  localparam logic READ_ARRAY_RESET_VAL = 1'b1;

  // timing
  localparam int CLK_FREQ_MHZ = 125;
  localparam int LOCK_PROG_TIME_NS = 1000;
  localparam int LOCK_PROG_CYCLES = (LOCK_PROG_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int CNT_W = 8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SECOND = 4'b0010,
    ST_LOCKPROG = 4'b0100,
    ST_BLANK = 4'b1000
  } flbs_state_type;
endpackage

// >>> verilog/flbs_lock_store.sv
// Purpose: one lock bit per block, cleared by the lock-bit program
// Assumes: volatile model of the lock bits, all unlocked after reset
// Notes: read port is combinational
`timescale 1ns/10ps
module flbs_lock_store
  import flbs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // lock write
  input wire logic wr_en_i,
  input wire logic [BLK_W-1:0] wr_block_i,
  // lock read
  input wire logic [BLK_W-1:0] rd_block_i,
  output logic rd_lock_o
);
  logic [NUM_BLOCKS-1:0] lock_bits;

  genvar g;
  generate
    for (g = 0; g < NUM_BLOCKS; g++)
    begin : g_lock
      always_ff @(posedge clk_i or negedge resetn_i)
      begin
        if (!resetn_i)
          lock_bits[g] <= LOCK_RESET_VAL;
        else if (wr_en_i && (wr_block_i == BLK_W'(g)))
          lock_bits[g] <= 1'b0;
      end
    end
  endgenerate

  assign rd_lock_o = lock_bits[rd_block_i];
endmodule // flbs_lock_store

// >>> verilog/flbs_blank_scan.sv
// Purpose: walks one block and checks that every byte reads blank
// Assumes: array read data valid one cycle after rd_en_o
// Notes: done_o and fail_o are one-cycle pulses together
`timescale 1ns/10ps
module flbs_blank_scan
  import flbs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // control
  input wire logic start_i,
  input wire logic [BLK_W-1:0] block_i,
  output logic done_o,
  output logic fail_o,
  // array read
  output logic rd_en_o,
  output logic [ADDR_W-1:0] rd_addr_o,
  input wire logic [DATA_W-1:0] rd_data_i
);
  localparam logic [BLK_SHIFT-1:0] OFFS_MAX = '1;

  logic active;
  logic [BLK_SHIFT-1:0] offs;
  logic [BLK_W-1:0] block;
  logic chk_valid;
  logic chk_last;
  logic mism;
  wire last_offs = (offs == OFFS_MAX);
  wire byte_bad = chk_valid && (rd_data_i != BLANK_BYTE);

  assign rd_en_o = active;
  assign rd_addr_o = {block, offs};

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      active <= 1'b0;
      offs <= '0;
      block <= '0;
    end
    else if (start_i)
    begin
      active <= 1'b1;
      offs <= '0;
      block <= block_i;
    end
    else if (active)
    begin
      active <= !last_offs;
      offs <= offs + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      chk_valid <= 1'b0;
      chk_last <= 1'b0;
      mism <= 1'b0;
      done_o <= 1'b0;
      fail_o <= 1'b0;
    end
    else
    begin
      chk_valid <= active;
      chk_last <= active && last_offs;
      mism <= start_i ? 1'b0 : (mism | byte_bad);
      done_o <= chk_valid && chk_last;
      fail_o <= chk_valid && chk_last && (mism | byte_bad);
    end
  end
endmodule // flbs_blank_scan

// >>> verilog/flbs_seq.sv
// Purpose: command sequencer for lock-bit program, lock status read, blank check and status
// Assumes: command writes are one-cycle strobes synchronous to clk_i
// Notes: writes are ignored while the ready flag is low
// Notes on behaviour
// - 77h then D0h at a block start clears that block's lock bit.
// - Ready flag reports completion of a lock-bit write.
// - 71h then D0h at a block start copies lock state to lock data flag.
// - 25h then D0h in a block starts checking every byte is FFh.
// - Ready low during blank check, high when it finishes.
// - A non-FFh byte sets erase/blank error, program error untouched.
// - A badly written sequence sets both error flags.
// - Block erase second cycle other than D0h or FFh is a sequence error.
// - Erase during suspend or any command to the suspended block is an error.
// - Failed auto-erase sets erase/blank error only.
// - Failed program or lock program sets program error only.
// - FFh in a second cycle, except after 40h, drops the command and enters read array.
// - 50h clears both error flags.
// - Commands and data are bytes.
// - Ready flag is 0 busy, 1 ready.
`timescale 1ns/10ps
module flbs_seq
  import flbs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // command write cycles
  input wire logic cmd_wr_i,
  input wire logic [ADDR_W-1:0] cmd_addr_i,
  input wire logic [DATA_W-1:0] cmd_data_i,
  // rest of the sequencer
  input wire logic ext_busy_i,
  input wire logic erase_suspend_i,
  input wire logic [BLK_W-1:0] suspend_block_i,
  input wire logic erase_fail_i,
  input wire logic prog_fail_i,
  input wire logic lock_fail_i,
  output logic program_start_o,
  output logic erase_start_o,
  output logic [ADDR_W-1:0] op_addr_o,
  output logic [DATA_W-1:0] op_data_o,
  output logic read_array_mode_o,
  // array read for blank check
  output logic rd_en_o,
  output logic [ADDR_W-1:0] rd_addr_o,
  input wire logic [DATA_W-1:0] rd_data_i,
  // status
  output logic [DATA_W-1:0] flash_status_register_o,
  output logic ready_flag_o,
  output logic erase_suspend_flag_o,
  output logic erase_blank_error_flag_o,
  output logic program_error_flag_o,
  output logic lock_bit_data_flag_o
);
  localparam logic [CNT_W-1:0] LOCK_CNT_LOAD = CNT_W'(LOCK_PROG_CYCLES - 1);
  localparam int LOCK_WAIT = LOCK_PROG_CYCLES;

  flbs_state_type state;
  flbs_state_type next_state;
  logic [DATA_W-1:0] pend_cmd;
  logic [ADDR_W-1:0] first_addr;
  logic [CNT_W-1:0] lock_cnt;
  logic lock_rd;
  logic scan_done;
  logic scan_fail;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire busy_own = (state == ST_LOCKPROG) || (state == ST_BLANK);
  assign ready_flag_o = !busy_own && !ext_busy_i;
  wire wr_take = cmd_wr_i && ready_flag_o;
  wire first = wr_take && (state == ST_IDLE);
  wire sec = wr_take && (state == ST_SECOND);
  wire [BLK_W-1:0] blk = cmd_addr_i[ADDR_W-1:BLK_SHIFT];
  wire [BLK_W-1:0] lock_blk = first_addr[ADDR_W-1:BLK_SHIFT];
  wire blk_start = (cmd_addr_i[BLK_SHIFT-1:0] == '0);
  wire addr_same = (cmd_addr_i == first_addr);
  wire confirm = (cmd_data_i == CMD_CONFIRM);
  wire is_ff = (cmd_data_i == BLANK_BYTE);
  wire is_two = (cmd_data_i == CMD_PROGRAM) || (cmd_data_i == CMD_BLOCK_ERASE) ||
    (cmd_data_i == CMD_LOCK_PROGRAM) || (cmd_data_i == CMD_LOCK_READ) ||
    (cmd_data_i == CMD_BLANK_CHECK);
  wire clear_cmd = first && (cmd_data_i == CMD_CLEAR_STATUS);
  wire first_ff = first && (cmd_data_i == CMD_READ_ARRAY);
  wire first_two = first && is_two;
  wire first_bad = first && !clear_cmd && !first_ff && !is_two;
  wire pend_prog = (pend_cmd == CMD_PROGRAM);
  wire sec_abort = sec && is_ff && !pend_prog;
  wire susp_hit = erase_suspend_i && (blk == suspend_block_i);
  wire base_ok = confirm && !susp_hit;
  wire go_prog = sec && pend_prog && addr_same && !susp_hit;
  wire go_erase = sec && (pend_cmd == CMD_BLOCK_ERASE) && base_ok && !erase_suspend_i;
  wire go_lock = sec && (pend_cmd == CMD_LOCK_PROGRAM) && base_ok && blk_start &&
    addr_same;
  wire go_lread = sec && (pend_cmd == CMD_LOCK_READ) && base_ok && blk_start;
  wire go_blank = sec && (pend_cmd == CMD_BLANK_CHECK) && base_ok && !erase_suspend_i;
  wire sec_good = go_prog || go_erase || go_lock || go_lread || go_blank;
  wire sec_bad = sec && !sec_abort && !sec_good;
  wire seq_err = first_bad || sec_bad;
  wire lock_done = (state == ST_LOCKPROG) && (lock_cnt == '0);
  wire lock_we = lock_done && !lock_fail_i;
  wire eb_set = seq_err || (scan_done && scan_fail) || erase_fail_i;
  wire pe_set = seq_err || prog_fail_i || (lock_done && lock_fail_i);
  wire next_eb = eb_set || (erase_blank_error_flag_o && !clear_cmd);
  wire next_pe = pe_set || (program_error_flag_o && !clear_cmd);
  wire next_ram = (first_ff || sec_abort) ? 1'b1 : (wr_take ? 1'b0 : read_array_mode_o);

  assign erase_suspend_flag_o = erase_suspend_i;

  always_comb
  begin
    flash_status_register_o = '0;
    flash_status_register_o[ST_READY_BIT] = ready_flag_o;
    flash_status_register_o[ST_SUSPEND_BIT] = erase_suspend_flag_o;
    flash_status_register_o[ST_EB_ERR_BIT] = erase_blank_error_flag_o;
    flash_status_register_o[ST_PROG_ERR_BIT] = program_error_flag_o;
    flash_status_register_o[ST_LOCK_BIT] = lock_bit_data_flag_o;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state machine
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (first_two)
          next_state = ST_SECOND;
      ST_SECOND:
        if (go_lock)
          next_state = ST_LOCKPROG;
        else if (go_blank)
          next_state = ST_BLANK;
        else if (sec)
          next_state = ST_IDLE;
      ST_LOCKPROG:
        if (lock_done)
          next_state = ST_IDLE;
      ST_BLANK:
        if (scan_done)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pend_cmd <= '0;
      first_addr <= '0;
    end
    else if (first_two)
    begin
      pend_cmd <= cmd_data_i;
      first_addr <= cmd_addr_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      lock_cnt <= '0;
    else if (go_lock)
      lock_cnt <= LOCK_CNT_LOAD;
    else if (lock_cnt != '0)
      lock_cnt <= lock_cnt - 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and outputs
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      erase_blank_error_flag_o <= 1'b0;
      program_error_flag_o <= 1'b0;
      lock_bit_data_flag_o <= LOCK_DATA_RESET_VAL;
      read_array_mode_o <= READ_ARRAY_RESET_VAL;
    end
    else
    begin
      erase_blank_error_flag_o <= next_eb;
      program_error_flag_o <= next_pe;
      read_array_mode_o <= next_ram;
      if (go_lread)
        lock_bit_data_flag_o <= lock_rd;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      program_start_o <= 1'b0;
      erase_start_o <= 1'b0;
      op_addr_o <= '0;
      op_data_o <= '0;
    end
    else
    begin
      program_start_o <= go_prog;
      erase_start_o <= go_erase;
      if (go_prog || go_erase)
        op_addr_o <= cmd_addr_i;
      if (go_prog)
        op_data_o <= cmd_data_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // submodules
  flbs_lock_store u_lock (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .wr_en_i(lock_we),
    .wr_block_i(lock_blk),
    .rd_block_i(blk),
    .rd_lock_o(lock_rd)
  );

  flbs_blank_scan u_scan (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .start_i(go_blank),
    .block_i(blk),
    .done_o(scan_done),
    .fail_o(scan_fail),
    .rd_en_o(rd_en_o),
    .rd_addr_o(rd_addr_o),
    .rd_data_i(rd_data_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_lock_time;
    go_lock |-> ##LOCK_WAIT lock_done;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock program length wrong");

  property p_lock_cleared;
    lock_we |=> (u_lock.lock_bits[lock_blk] == 1'b0);
  endproperty
  a_lock_cleared: assert property (p_lock_cleared) else $error("lock bit not cleared");

  property p_lock_busy;
    go_lock |=> !ready_flag_o [*8];
  endproperty
  a_lock_busy: assert property (p_lock_busy) else $error("ready during lock program");

  property p_lread;
    go_lread |=> (lock_bit_data_flag_o == $past(lock_rd));
  endproperty
  a_lread: assert property (p_lread) else $error("lock data flag not loaded");

  property p_blank_start;
    go_blank |=> rd_en_o && (rd_addr_o == {$past(blk), {BLK_SHIFT{1'b0}}});
  endproperty
  a_blank_start: assert property (p_blank_start) else $error("blank scan start wrong");

  property p_blank_ready;
    (state == ST_BLANK) && !scan_done |=> !ready_flag_o || (state == ST_IDLE);
  endproperty
  a_blank_ready: assert property (p_blank_ready) else $error("ready during blank check");

  property p_blank_end;
    scan_done && !ext_busy_i |=> ##0 (state == ST_IDLE);
  endproperty
  a_blank_end: assert property (p_blank_end) else $error("blank check did not end");

  property p_blank_err;
    scan_done && scan_fail && !pe_set |=>
      erase_blank_error_flag_o && (program_error_flag_o == $past(program_error_flag_o));
  endproperty
  a_blank_err: assert property (p_blank_err) else $error("blank error coding wrong");

  property p_seq_err;
    seq_err |=> erase_blank_error_flag_o && program_error_flag_o;
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("sequence error not flagged");

  property p_erase_data;
    sec && (pend_cmd == CMD_BLOCK_ERASE) && !confirm && !is_ff |-> seq_err;
  endproperty
  a_erase_data: assert property (p_erase_data) else $error("bad erase data accepted");

  property p_susp_block;
    sec && susp_hit && !sec_abort |-> seq_err;
  endproperty
  a_susp_block: assert property (p_susp_block) else $error("suspended block accepted");

  property p_prog_err;
    prog_fail_i && !seq_err && !erase_fail_i && !scan_done && !clear_cmd |=>
      program_error_flag_o && (erase_blank_error_flag_o == $past(erase_blank_error_flag_o));
  endproperty
  a_prog_err: assert property (p_prog_err) else $error("program error coding wrong");

  property p_abort;
    sec_abort |=> read_array_mode_o && (state == ST_IDLE) && !program_start_o;
  endproperty
  a_abort: assert property (p_abort) else $error("second cycle abort failed");

  property p_clear;
    clear_cmd && !erase_fail_i && !prog_fail_i |=>
      !erase_blank_error_flag_o && !program_error_flag_o;
  endproperty
  a_clear: assert property (p_clear) else $error("clear status failed");

  property p_sticky;
    erase_blank_error_flag_o && !clear_cmd |=> erase_blank_error_flag_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("error flag dropped");

  c_lock: cover property (go_lock ##[1:200] lock_we);
  c_blank_fail: cover property (go_blank ##300 (state == ST_BLANK) ##[1:1000]
    (scan_done && scan_fail));
  c_abort: cover property (first_two ##[1:20] sec_abort);
  c_seq_err: cover property (seq_err ##[1:20] clear_cmd);
endmodule // flbs_seq

// >>> sim/flbs_cpu.sv
// Purpose: cpu side of the command port, issues write cycles and polls ready
// Assumes: one write strobe per bus cycle, launched just after a rising edge
// Notes: idle address and data lines show the inverse of the last cycle
`timescale 1ns/10ps
module flbs_cpu
  import flbs_pkg::*;
(
  // clock
  input wire logic clk_i,
  // status seen by the cpu
  input wire logic ready_flag_i,
  input wire logic erase_suspend_flag_i,
  // command write cycles
  output logic cmd_wr_o,
  output logic [ADDR_W-1:0] cmd_addr_o,
  output logic [DATA_W-1:0] cmd_data_o
);
  initial
  begin
    cmd_wr_o = 1'b0;
    cmd_addr_o = 16'h0000;
    cmd_data_o = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_i);
    cmd_wr_o <= 1'b1;
    cmd_addr_o <= a;
    cmd_data_o <= d;
    @(posedge clk_i);
    cmd_wr_o <= 1'b0;
    cmd_addr_o <= ~a;
    cmd_data_o <= ~d;
  endtask

  // two-cycle command, same address in both cycles
  task automatic pair(input logic [DATA_W-1:0] c1, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] c2);
    if (c1 == CMD_BLANK_CHECK && erase_suspend_flag_i)
      return;
    wr(a, c1);
    wr(a, c2);
  endtask

  // edges until ready reads high; status is read only after that
  task automatic wait_ready(output int n);
    n = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      n++;
    end while (ready_flag_i !== 1'b1 && n < 4000);
  endtask
endmodule // flbs_cpu

// >>> sim/flbs_seq_test.sv
// Purpose: self-checking bench for the lock, blank-check and status sequencer
// Assumes: flbs_cpu issues command writes, a behavioural array answers reads
// Notes: lock programming and blank checks run at full length
`timescale 1ns/10ps
module flbs_seq_test
  import flbs_pkg::*;
;
  typedef struct packed {
    logic [DATA_W-1:0] c1;
    logic [ADDR_W-1:0] a1;
    logic [DATA_W-1:0] c2;
    logic [ADDR_W-1:0] a2;
    logic e, p, l, ra;
  } flbs_row_type;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ext_busy = 1'b0, susp = 1'b0, erase_fail = 1'b0, prog_fail = 1'b0;
  logic lock_fail = 1'b0, bad_en = 1'b0;
  logic [BLK_W-1:0] susp_blk = 6'h00;
  logic [ADDR_W-1:0] bad_addr = 16'h0000;
  logic [DATA_W-1:0] rd_data = 8'h00;
  logic cmd_wr, rd_en, ready, susp_flag, eb, pe, lk, ra, ps, es;
  logic [ADDR_W-1:0] cmd_addr, rd_addr, op_a;
  logic [DATA_W-1:0] cmd_data, status, op_d;
  flbs_row_type rows [11];
  int fails = 0, n_compared = 0, cycles = 0, n, i;

  always #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  flbs_cpu cpu_u (.clk_i(clk), .ready_flag_i(ready), .erase_suspend_flag_i(susp_flag),
    .cmd_wr_o(cmd_wr), .cmd_addr_o(cmd_addr), .cmd_data_o(cmd_data));

  flbs_seq dut_u (.clk_i(clk), .resetn_i(resetn), .cmd_wr_i(cmd_wr), .cmd_addr_i(cmd_addr),
    .cmd_data_i(cmd_data), .ext_busy_i(ext_busy), .erase_suspend_i(susp),
    .suspend_block_i(susp_blk), .erase_fail_i(erase_fail), .prog_fail_i(prog_fail),
    .lock_fail_i(lock_fail), .program_start_o(ps), .erase_start_o(es), .op_addr_o(op_a),
    .op_data_o(op_d), .read_array_mode_o(ra), .rd_en_o(rd_en), .rd_addr_o(rd_addr),
    .rd_data_i(rd_data), .flash_status_register_o(status), .ready_flag_o(ready),
    .erase_suspend_flag_o(susp_flag), .erase_blank_error_flag_o(eb),
    .program_error_flag_o(pe), .lock_bit_data_flag_o(lk));

  // array: data one cycle after the read, garbage when not reading
  always @(posedge clk)
    rd_data <= rd_en ? ((bad_en && rd_addr == bad_addr) ? 8'h00 : BLANK_BYTE) : ~rd_data;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic flags(input logic e, input logic p, input logic l);
    chk("status", {8'h00, 1'b1, susp, e, p, 3'h0, l}, {8'h00, status});
    chk("flags", {13'h0000, e, p, l}, {13'h0000, eb, pe, lk});
  endtask

  task automatic cmd_wait(input logic [DATA_W-1:0] c1, input logic [ADDR_W-1:0] a);
    cpu_u.pair(c1, a, CMD_CONFIRM);
    cpu_u.wait_ready(n);
  endtask

  // one-cycle fail pulse: program fail when pf is 1, erase fail otherwise
  task automatic pulse(input logic pf);
    @(posedge clk);
    if (pf)
      prog_fail <= 1'b1;
    else
      erase_fail <= 1'b1;
    @(posedge clk);
    prog_fail <= 1'b0;
    erase_fail <= 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic end_sim();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows[0] = {8'h71, 16'h0400, 8'hd0, 16'h0400, 4'b0010};
    rows[1] = {8'h77, 16'h0800, 8'hd0, 16'h0800, 4'b0010};
    rows[2] = {8'h71, 16'h0000, 8'hd0, 16'h0800, 4'b0000};
    rows[3] = {8'h77, 16'h0800, 8'hd0, 16'h0c00, 4'b1100};
    rows[4] = {8'h71, 16'h0000, 8'hd0, 16'h0801, 4'b1100};
    rows[5] = {8'h20, 16'h0000, 8'h55, 16'h1000, 4'b1100};
    rows[6] = {8'h20, 16'h0000, 8'hff, 16'h1000, 4'b0001};
    rows[7] = {8'h77, 16'h0c00, 8'hff, 16'h0c00, 4'b0001};
    rows[8] = {8'h25, 16'h0000, 8'h33, 16'h1000, 4'b1100};
    rows[9] = {8'h12, 16'h0000, 8'hff, 16'h0000, 4'b1101};
    rows[10] = {8'h25, 16'h0000, 8'hd0, 16'h1555, 4'b0000};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("reset status", 16'h0080, {8'h00, status});
    chk("reset read array", 16'h0001, {15'h0000, ra});
    for (i = 0; i < 11; i++)
    begin
      cpu_u.wr(16'h0000, CMD_CLEAR_STATUS);
      cpu_u.wr(rows[i].a1, rows[i].c1);
      cpu_u.wr(rows[i].a2, rows[i].c2);
      cpu_u.wait_ready(n);
      flags(rows[i].e, rows[i].p, rows[i].l);
      chk("read array", {15'h0000, rows[i].ra}, {15'h0000, ra});
    end
    // failed lock write: busy for the programming time, program error only
    lock_fail <= 1'b1;
    cmd_wait(CMD_LOCK_PROGRAM, 16'h0c00);
    chk("lock busy", 16'h0001, (n >= LOCK_PROG_CYCLES - 1 && n <= LOCK_PROG_CYCLES + 2));
    flags(1'b0, 1'b1, 1'b0);
    lock_fail <= 1'b0;
    cmd_wait(CMD_LOCK_READ, 16'h0c00);
    flags(1'b0, 1'b1, 1'b1);
    cpu_u.wr(16'h0000, CMD_CLEAR_STATUS);
    cpu_u.wait_ready(n);
    flags(1'b0, 1'b0, 1'b1);
    // blank check that finds the last byte of block 5 written
    bad_en <= 1'b1;
    bad_addr <= 16'h17ff;
    cpu_u.pair(CMD_BLANK_CHECK, 16'h1600, CMD_CONFIRM);
    repeat (3) @(posedge clk);
    #1;
    chk("blank ready", 16'h0000, {15'h0000, ready});
    cpu_u.wait_ready(n);
    chk("blank busy", 16'h0001, (n >= 1018 && n <= 1030));
    flags(1'b1, 1'b0, 1'b1);
    bad_en <= 1'b0;
    cpu_u.wr(16'h0000, CMD_CLEAR_STATUS);
    pulse(1'b0);
    flags(1'b1, 1'b0, 1'b1);
    cpu_u.wr(16'h0000, CMD_CLEAR_STATUS);
    pulse(1'b1);
    flags(1'b0, 1'b1, 1'b1);
    // busy elsewhere: ready low and the clear is ignored
    ext_busy <= 1'b1;
    cpu_u.wr(16'h0000, CMD_CLEAR_STATUS);
    #1;
    chk("busy ready", 16'h0000, {15'h0000, ready});
    chk("busy errors", 16'h0001, {14'h0000, eb, pe});
    ext_busy <= 1'b0;
    // erase suspended on block 2
    cpu_u.wr(16'h0000, CMD_CLEAR_STATUS);
    susp <= 1'b1;
    susp_blk <= 6'h02;
    cmd_wait(CMD_BLOCK_ERASE, 16'h1000);
    flags(1'b1, 1'b1, 1'b1);
    cpu_u.wr(16'h0000, CMD_CLEAR_STATUS);
    cmd_wait(CMD_LOCK_READ, 16'h0800);
    flags(1'b1, 1'b1, 1'b1);
    susp <= 1'b0;
    // reset in mid-run clears flags and unlocks block 2 again
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("second reset", 16'h0080, {8'h00, status});
    @(posedge clk);
    resetn <= 1'b1;
    cmd_wait(CMD_LOCK_READ, 16'h0800);
    flags(1'b0, 1'b0, 1'b1);
    // program with FFh data is programmed, not an abort; erase starts on D0h
    cpu_u.pair(CMD_PROGRAM, 16'h2345, BLANK_BYTE);
    #1;
    chk("program start", 16'h0001, {15'h0000, ps});
    chk("program addr", 16'h2345, op_a);
    chk("program data", 16'h00ff, {8'h00, op_d});
    chk("program read array", 16'h0000, {15'h0000, ra});
    cpu_u.pair(CMD_BLOCK_ERASE, 16'h1400, CMD_CONFIRM);
    #1;
    chk("erase start", 16'h0002, {14'h0000, es, ps});
    chk("erase addr", 16'h1400, op_a);
    flags(1'b0, 1'b0, 1'b1);
    end_sim();
  end
endmodule // flbs_seq_test
